// ==== clk_synth_pkg.sv ====
// Function
// - output rates selectable; top system rate 32MHz (2X at 64MHz).
// - reference comes from relaxation oscillator, crystal/resonator or external clock.
// - bypass path passes the selected reference straight to the 2X clock.
// - pll path makes 2X equal to reference times eight over postscaler.
// - three-bit postscaler divides by 1, 2, 4, 8, 16 or 32 only.
// - 2X clock at twice the system rate goes to the integration unit.
// - 3X clock at three times the system rate goes to PWM and timers.
// - loss of the pll reference triggers a safety shutdown.
// - relaxation and crystal oscillators can each be powered down alone.
// - relaxation oscillator has a standby state apart from power-down.
// - software can power down the pll.
// - after reset the relaxation oscillator is on and selected, select bit zero.
// - ten-bit trim in bits 0 to 9 adjusts the relaxation oscillator.
// - factory trim is copied into the factory option register in the first cycle after reset.
`default_nettype none
package clk_synth_pkg;
   localparam int SYS_PERIOD_PS = 25000;
   localparam int MAX_SYS_MHZ = 32;
   localparam int LOR_TIME_NS = 1000;
   localparam int LOR_CYCLES = (LOR_TIME_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
   localparam int PLL_MUL = 8;
   localparam int X3_MUL = 3;
   localparam int DIV_W = 6;
   localparam logic [DIV_W-1:0] X3_DIV = 6'h02;
   localparam logic [DIV_W-1:0] POST_MAX_DIV = 6'h20;
   localparam int TRIM_LSB = 0;
   localparam int TRIM_MSB = 9;
   localparam int TRIM_W = TRIM_MSB - TRIM_LSB + 1;
   localparam logic [TRIM_W-1:0] TRIM_RST = 10'h200;
   localparam logic REF_SELECT_RST = 1'b0;

   typedef enum logic [1:0] {
      SRC_RELAX = 2'b00,
      SRC_XTAL = 2'b01,
      SRC_EXT = 2'b10
   } ref_src_e;

   typedef enum logic {
      PH_LOAD = 1'b0,
      PH_RUN = 1'b1
   } boot_phase_e;

   function automatic logic [DIV_W-1:0] post_div(input logic [2:0] code);
      logic [DIV_W-1:0] d;
      d = POST_MAX_DIV;
      unique case (code)
         3'h0: d = 6'h01;
         3'h1: d = 6'h02;
         3'h2: d = 6'h04;
         3'h3: d = 6'h08;
         3'h4: d = 6'h10;
         default: d = POST_MAX_DIV;
      endcase
      return d;
   endfunction : post_div
endpackage : clk_synth_pkg
`default_nettype wire

// ==== clock_synthesis_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module clock_synthesis_unit
   import clk_synth_pkg::*;
#(
   parameter int LOR_CYC = LOR_CYCLES,
   parameter int CRED_W = 6
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic relax_clk_i,
   input wire logic xtal_clk_i,
   input wire logic ext_clk_i,
   input wire logic ref_select_i,
   input wire logic ext_kind_i,
   input wire logic pll_select_i,
   input wire logic [2:0] post_code_i,
   input wire logic relax_pd_i,
   input wire logic relax_stby_i,
   input wire logic xtal_pd_i,
   input wire logic pll_pd_i,
   input wire logic trim_wr_i,
   input wire logic [TRIM_W-1:0] trim_data_i,
   input wire logic [TRIM_W-1:0] factory_trim_i,
   input wire logic loss_clear_i,
   output logic clk2x_o,
   output logic clk3x_o,
   output logic relax_en_o,
   output logic relax_stby_o,
   output logic xtal_en_o,
   output logic pll_en_o,
   output logic [TRIM_W-1:0] trim_o,
   output logic [TRIM_W-1:0] factory_opt_o,
   output logic factory_valid_o,
   output logic ref_loss_o,
   output logic [1:0] active_src_o
);
   localparam int WD_W = $clog2(LOR_CYC + 1);
   localparam logic [WD_W-1:0] WD_LAST = WD_W'(LOR_CYC - 1);

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] filt;
      logic prev;
      ref_src_e src;
      logic pll_sel;
      logic [2:0] post;
      logic relax_pd;
      logic relax_stby;
      logic xtal_pd;
      logic pll_pd;
      logic [TRIM_W-1:0] trim;
      logic [TRIM_W-1:0] fopt;
      boot_phase_e phase;
      logic [WD_W-1:0] wd;
      logic loss;
      logic x2;
      logic x3;
   } csu_s;

   csu_s st_ff;
   csu_s nxt;
   ref_src_e src_n;
   logic cur_lvl;
   logic cfg_change;
   logic rise;
   logic pll_active;
   logic set_loss;

   rate_if pll_if ();
   rate_if x3_if ();

   // external source choice is software's; stability before switching is its duty
   assign src_n = !ref_select_i ? SRC_RELAX : (ext_kind_i ? SRC_EXT : SRC_XTAL);
   // a stopped oscillator yields no edges, so the watchdog sees it
   always_comb begin
      unique case (st_ff.src)
         SRC_RELAX: cur_lvl = st_ff.filt[0] & ~st_ff.relax_pd;
         SRC_XTAL: cur_lvl = st_ff.filt[1] & ~st_ff.xtal_pd;
         SRC_EXT: cur_lvl = st_ff.filt[2];
         default: cur_lvl = 1'b0;
      endcase
   end
   assign cfg_change = (src_n != st_ff.src) || (pll_select_i != st_ff.pll_sel)
      || (post_code_i != st_ff.post);
   assign rise = cur_lvl & ~st_ff.prev & ~cfg_change;
   assign pll_active = st_ff.pll_sel & ~st_ff.pll_pd;
   assign set_loss = pll_active && !rise && !cfg_change && st_ff.wd == WD_LAST;

   // multiplier of 8 on an 8MHz reference at divide 1 gives the 64MHz 2X ceiling
   assign pll_if.ev = rise & pll_active;
   assign pll_if.clr = cfg_change | ~pll_active;
   assign pll_if.div = post_div(st_ff.post);
   assign x3_if.ev = st_ff.x2;
   assign x3_if.clr = cfg_change | st_ff.loss;
   assign x3_if.div = X3_DIV;

   rate_gen #(.MUL(PLL_MUL), .CRED_W(CRED_W)) u_pll (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .rif(pll_if.gen)
   );
   // 3 credits per 2X tick, one 3X tick per 2 credits: 1.5x the 2X rate
   rate_gen #(.MUL(X3_MUL), .CRED_W(CRED_W)) u_x3 (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .rif(x3_if.gen)
   );

   always_comb begin
      nxt = st_ff;
      nxt.s1 = {ext_clk_i, xtal_clk_i, relax_clk_i};
      nxt.s2 = st_ff.s1;
      nxt.s3 = st_ff.s2;
      nxt.filt = (st_ff.s2 & ~(st_ff.s2 ^ st_ff.s3)) | (st_ff.filt & (st_ff.s2 ^ st_ff.s3));
      nxt.src = src_n;
      nxt.pll_sel = pll_select_i;
      nxt.post = post_code_i;
      nxt.relax_pd = relax_pd_i;
      nxt.relax_stby = relax_stby_i;
      nxt.xtal_pd = xtal_pd_i;
      nxt.pll_pd = pll_pd_i;
      // forcing prev high drops the partial half period of the new source
      nxt.prev = cfg_change ? 1'b1 : cur_lvl;
      if (st_ff.phase == PH_LOAD) begin
         nxt.fopt = factory_trim_i;
         nxt.phase = PH_RUN;
      end
      if (trim_wr_i) begin
         nxt.trim = trim_data_i;
      end
      if (!pll_active || rise || cfg_change) begin
         nxt.wd = '0;
      end else if (st_ff.wd != WD_LAST) begin
         nxt.wd = WD_W'(st_ff.wd + 1'b1);
      end
      if (set_loss) begin
         nxt.loss = 1'b1;
      end else if (loss_clear_i) begin
         nxt.loss = 1'b0;
      end
      nxt.x2 = ~nxt.loss & (st_ff.pll_sel ? pll_if.tick : rise);
      nxt.x3 = ~nxt.loss & x3_if.tick;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.prev <= 1'b1;
         st_ff.trim <= TRIM_RST;
      end else begin
         st_ff <= nxt;
      end
   end

   assign clk2x_o = st_ff.x2;
   assign clk3x_o = st_ff.x3;
   assign relax_en_o = ~st_ff.relax_pd;
   assign relax_stby_o = st_ff.relax_stby & ~st_ff.relax_pd;
   assign xtal_en_o = ~st_ff.xtal_pd;
   assign pll_en_o = ~st_ff.pll_pd;
   assign trim_o = st_ff.trim;
   assign factory_opt_o = st_ff.fopt;
   assign factory_valid_o = st_ff.phase == PH_RUN;
   assign ref_loss_o = st_ff.loss;
   assign active_src_o = st_ff.src;

   chk_reset_relax: assert property (
      @(posedge clk_sys_i) rst_i |-> relax_en_o && active_src_o == SRC_RELAX
         && !ref_loss_o && !clk2x_o)
      else $error("reset state not on relaxation oscillator");
   chk_bypass_pass: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      !st_ff.pll_sel && rise && !set_loss && !st_ff.loss |=> clk2x_o)
      else $error("bypass edge not passed to 2X");
   chk_post_div: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      pll_if.div inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20})
      else $error("postscaler divisor illegal");
   chk_post_high: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      post_code_i > 3'h5 && !cfg_change |-> pll_if.div == POST_MAX_DIV)
      else $error("high postscaler code not divide by 32");
   chk_pll_off: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      pll_active == 1'b0 && st_ff.pll_sel ##1 st_ff.pll_sel |=> !clk2x_o)
      else $error("2X runs with pll powered down");
   chk_loss_timeout: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      set_loss |=> ref_loss_o ##1 !(clk2x_o || clk3x_o))
      else $error("lost reference not shut down");
   chk_loss_gate: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      ref_loss_o |-> !clk2x_o && !clk3x_o)
      else $error("clock out during shutdown");
   chk_factory_copy: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      !factory_valid_o |=> factory_valid_o && factory_opt_o == $past(factory_trim_i))
      else $error("factory trim not captured");
   chk_trim_write: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      trim_wr_i |=> trim_o == $past(trim_data_i))
      else $error("trim write lost");
   chk_pd_split: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      xtal_pd_i && !relax_pd_i |=> !xtal_en_o && relax_en_o)
      else $error("oscillator power-down not independent");
   chk_stby_apart: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      relax_stby_o |-> relax_en_o)
      else $error("standby reported while powered down");
   chk_stby_entry: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      relax_stby_i && !relax_pd_i |=> relax_stby_o && relax_en_o)
      else $error("standby request not taken");
   chk_switch_clean: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      cfg_change && !st_ff.pll_sel |=> !clk2x_o)
      else $error("pulse emitted on a switch");

   cov_bypass_tick: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      !st_ff.pll_sel && clk2x_o);
   cov_pll_tick: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      st_ff.pll_sel && clk2x_o);
   cov_x3_tick: cover property (@(posedge clk_sys_i) disable iff (rst_i) clk3x_o);
   cov_loss: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(ref_loss_o));
endmodule : clock_synthesis_unit
`default_nettype wire

// ==== rate_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
// each input event earns MUL credits; one credit spent per cycle; every div-th spend ticks
module rate_gen
   import clk_synth_pkg::*;
#(
   parameter int MUL = 8,
   parameter int CRED_W = 6
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   rate_if.gen rif
);
   typedef struct packed {
      logic [CRED_W-1:0] credit;
      logic [DIV_W-1:0] phase;
      logic tick;
   } rg_s;

   localparam logic [CRED_W:0] CRED_MAX = {1'b0, {CRED_W{1'b1}}};
   rg_s st_ff;
   rg_s nxt;
   logic spend;
   logic [CRED_W:0] sum;

   always_comb begin
      nxt = st_ff;
      spend = st_ff.credit != '0;
      // saturates when the event rate times MUL exceeds one per cycle
      sum = {1'b0, st_ff.credit} + (rif.ev ? CRED_W'(MUL) : '0) - {{CRED_W{1'b0}}, spend};
      nxt.credit = (sum > CRED_MAX) ? CRED_MAX[CRED_W-1:0] : sum[CRED_W-1:0];
      nxt.tick = spend && (st_ff.phase >= DIV_W'(rif.div - 1'b1));
      if (spend) begin
         nxt.phase = nxt.tick ? '0 : DIV_W'(st_ff.phase + 1'b1);
      end
      if (rif.clr) begin
         nxt = '0;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt;
      end
   end

   assign rif.tick = st_ff.tick;

   chk_credit_gain: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rif.ev && !rif.clr && st_ff.credit == '0 |=> st_ff.credit == CRED_W'(MUL))
      else $error("credit gain per event wrong");
   chk_clear_quiet: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rif.clr |=> !rif.tick && st_ff.credit == '0)
      else $error("clear left a pending tick");
   chk_tick_spacing: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      rif.tick && rif.div > 6'h01 && !rif.clr |=> !rif.tick)
      else $error("ticks closer than divisor allows");
endmodule : rate_gen
`default_nettype wire

// ==== rate_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rate_if;
   import clk_synth_pkg::*;
   logic ev;
   logic clr;
   logic [DIV_W-1:0] div;
   logic tick;
   modport src (output ev, output clr, output div, input tick);
   modport gen (input ev, input clr, input div, output tick);
endinterface : rate_if
`default_nettype wire

// ==== ref_osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// reference oscillators and the halving stage of the integration unit
module ref_osc_model (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [2:0] run_i,
   input wire logic [7:0] half_i,
   input wire logic relax_en_i,
   input wire logic xtal_en_i,
   input wire logic clk2x_i,
   input wire logic clk3x_i,
   input wire logic clr_i,
   output logic relax_clk_o,
   output logic xtal_clk_o,
   output logic ext_clk_o,
   output logic [15:0] cnt2x_o,
   output logic [15:0] cnt3x_o,
   output logic [15:0] cnt_sys_o
);
   logic [7:0] ph;
   logic sys_q;
   logic wrap;
   assign wrap = (ph + 8'h01) >= half_i;
   // a powered-down oscillator stops where it is, like the real part
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ph <= 8'h00;
         relax_clk_o <= 1'b0;
         xtal_clk_o <= 1'b0;
         ext_clk_o <= 1'b0;
         sys_q <= 1'b0;
         cnt2x_o <= 16'h0000;
         cnt3x_o <= 16'h0000;
         cnt_sys_o <= 16'h0000;
      end else begin
         ph <= wrap ? 8'h00 : ph + 8'h01;
         if (wrap && run_i[0] && relax_en_i) relax_clk_o <= ~relax_clk_o;
         if (wrap && run_i[1] && xtal_en_i) xtal_clk_o <= ~xtal_clk_o;
         if (wrap && run_i[2]) ext_clk_o <= ~ext_clk_o;
         if (clk2x_i) sys_q <= ~sys_q;
         cnt2x_o <= clr_i ? 16'h0000 : cnt2x_o + {15'h0000, clk2x_i};
         cnt3x_o <= clr_i ? 16'h0000 : cnt3x_o + {15'h0000, clk3x_i};
         cnt_sys_o <= clr_i ? 16'h0000 : cnt_sys_o + {15'h0000, clk2x_i & sys_q};
      end
   end
endmodule : ref_osc_model
`default_nettype wire

// ==== test_clock_synthesis_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_clock_synthesis_unit;
   import clk_synth_pkg::*;
   localparam int LOR = 100;
   // reset rises after time zero so the asynchronous reset sees a real edge
   logic clk_sys_i = 1'b0, rst_i = 1'b0, ref_select_i = 1'b0, ext_kind_i = 1'b0;
   logic pll_select_i = 1'b0;
   logic relax_pd_i = 0, relax_stby_i = 0, xtal_pd_i = 0, pll_pd_i = 0;
   logic trim_wr_i = 0, loss_clear_i = 0, clr = 0;
   logic [2:0] post_code_i = 3'h0, run = 3'h7;
   logic [7:0] half = 8'h04;
   logic [TRIM_W-1:0] trim_data_i = 10'h000, factory_trim_i = 10'h15a;
   logic clk2x_o, clk3x_o, relax_en_o, relax_stby_o, xtal_en_o, pll_en_o;
   logic factory_valid_o, ref_loss_o, relax_clk, xtal_clk, ext_clk;
   logic [TRIM_W-1:0] trim_o, factory_opt_o;
   logic [1:0] active_src_o;
   logic [15:0] cnt2x, cnt3x, cnt_sys;
   int num_errors = 0, num_checks = 0, e;
   clock_synthesis_unit #(.LOR_CYC(LOR)) i_clock_synthesis_unit (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .relax_clk_i(relax_clk), .xtal_clk_i(xtal_clk), .ext_clk_i(ext_clk),
      .ref_select_i(ref_select_i), .ext_kind_i(ext_kind_i), .pll_select_i(pll_select_i),
      .post_code_i(post_code_i), .relax_pd_i(relax_pd_i), .relax_stby_i(relax_stby_i),
      .xtal_pd_i(xtal_pd_i), .pll_pd_i(pll_pd_i), .trim_wr_i(trim_wr_i),
      .trim_data_i(trim_data_i), .factory_trim_i(factory_trim_i), .loss_clear_i(loss_clear_i),
      .clk2x_o(clk2x_o), .clk3x_o(clk3x_o), .relax_en_o(relax_en_o),
      .relax_stby_o(relax_stby_o), .xtal_en_o(xtal_en_o), .pll_en_o(pll_en_o), .trim_o(trim_o),
      .factory_opt_o(factory_opt_o), .factory_valid_o(factory_valid_o),
      .ref_loss_o(ref_loss_o), .active_src_o(active_src_o));
   ref_osc_model i_ref_osc_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run),
      .half_i(half), .relax_en_i(relax_en_o), .xtal_en_i(xtal_en_o), .clk2x_i(clk2x_o),
      .clk3x_i(clk3x_o), .clr_i(clr), .relax_clk_o(relax_clk), .xtal_clk_o(xtal_clk),
      .ext_clk_o(ext_clk), .cnt2x_o(cnt2x), .cnt3x_o(cnt3x), .cnt_sys_o(cnt_sys));
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic near(input string what, input logic [15:0] v, input int lo, input int hi);
      check(what, {15'h0000, (v >= lo && v <= hi)}, 16'h0001);
   endtask : near
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : cyc
   // settle first: a source or code change discards the partial period
   task automatic measure(input int n);
      cyc(20);
      clr = 1;
      cyc(1);
      clr = 0;
      cyc(n);
   endtask : measure
   task automatic set_src(input int s);
      ref_select_i = (s != 0);
      ext_kind_i = (s == 2);
      cyc(2);
   endtask : set_src
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (40000) @(posedge clk_sys_i);
      num_errors++;
      stop_test();
   end
   initial begin
      #1 rst_i = 1'b1;
      cyc(6);
      check("trim_rst", 16'(trim_o), 16'(TRIM_RST));
      check("opt_rst", 16'(factory_opt_o), 16'h0000);
      check("en_rst", 16'({relax_en_o, xtal_en_o, pll_en_o, factory_valid_o}), 16'h000e);
      check("src_rst", 16'(active_src_o), 16'h0000);
      rst_i = 0;
      cyc(1);
      check("opt", 16'(factory_opt_o), 16'h015a);
      check("opt_valid", 16'(factory_valid_o), 16'h0001);
      trim_data_i = factory_opt_o;
      trim_wr_i = 1;
      cyc(1);
      trim_wr_i = 0;
      cyc(1);
      check("trim", 16'(trim_o), 16'h015a);
      $display("test boot done");
      for (int s = 0; s < 3; s++) begin
         set_src(s);
         check("active_src", 16'(active_src_o), s[15:0]);
         measure(400);
         near("bypass_2x", cnt2x, 49, 51);
         near("sys_clk", cnt_sys, 24, 26);
      end
      $display("test bypass done");
      set_src(0);
      half = 8'h28;
      pll_select_i = 1;
      for (int c = 0; c < 8; c++) begin
         post_code_i = c[2:0];
         e = 160 >> ((c > 5) ? 5 : c);
         measure(1600);
         near("pll_2x", cnt2x, e - 2, e + 2);
         near("pll_3x", cnt3x, e * 3 / 2 - 3, e * 3 / 2 + 3);
      end
      $display("test pll done");
      post_code_i = 3'h3;
      run = 3'h0;
      cyc(LOR + 10);
      check("loss", 16'(ref_loss_o), 16'h0001);
      measure(200);
      check("loss_2x", cnt2x, 16'h0000);
      check("loss_3x", cnt3x, 16'h0000);
      loss_clear_i = 1;
      cyc(1);
      loss_clear_i = 0;
      cyc(LOR + 10);
      check("loss_again", 16'(ref_loss_o), 16'h0001);
      run = 3'h7;
      cyc(LOR);
      loss_clear_i = 1;
      cyc(1);
      loss_clear_i = 0;
      cyc(2);
      check("loss_clr", 16'(ref_loss_o), 16'h0000);
      measure(1600);
      near("resume_2x", cnt2x, 18, 22);
      $display("test loss done");
      pll_pd_i = 1;
      cyc(2);
      check("pll_en", 16'(pll_en_o), 16'h0000);
      measure(400);
      check("pll_pd_2x", cnt2x, 16'h0000);
      pll_pd_i = 0;
      pll_select_i = 0;
      half = 8'h04;
      relax_stby_i = 1;
      cyc(2);
      check("stby", 16'({relax_stby_o, relax_en_o}), 16'h0003);
      relax_stby_i = 0;
      relax_pd_i = 1;
      cyc(2);
      check("relax_pd", 16'({relax_en_o, xtal_en_o}), 16'h0001);
      measure(400);
      check("relax_pd_2x", cnt2x, 16'h0000);
      relax_pd_i = 0;
      set_src(1);
      xtal_pd_i = 1;
      cyc(2);
      check("xtal_pd", 16'({relax_en_o, xtal_en_o}), 16'h0002);
      measure(400);
      check("xtal_pd_2x", cnt2x, 16'h0000);
      xtal_pd_i = 0;
      set_src(2);
      relax_pd_i = 1;
      measure(400);
      near("ext_only_2x", cnt2x, 49, 51);
      $display("test power done");
      stop_test();
   end
endmodule : test_clock_synthesis_unit
`default_nettype wire
